// >>> logic/iommu_l2_cache_control.sv
// Operation
// - Device-table cache invalidation method comes from control bits 9:8.
// - Interrupt-table cache has the same four methods at its own bits 9:8.
// - Writing one to bit 10 flushes every entry of that cache.
// - Bit 13 makes all requests skip that cache, per cache.
// - Way-control low bits disable ways; all ways set disables the cache.
// - Index built from function, device, bus counts; software keeps sum in range.
// - Bit 3 picks whether reads or writes update replacement state on collision.
// - Two-bit replacement method at bits 1:0, reset value one.
// - Bit 4 enables parity; read-only bit 15 reports parity support.
// - Read-only way count at 23:16 and size exponent at 31:28.
// - Core bit 0 makes translation requests look up the page-table cache.
// - Core bit 1 lets first level keep invalid device entries as fully permitted.
// - Core bit 2 lets first level keep translation replies.
// - Invalid-entry hit refetches unless core bit 3 is set.
// - Walker and combiner credits reset to four and reload on field change.
// - Bits 10 and 11 return page entry instead of device entry on exclusion hits.
// - Combiner arbitration round-robin, or walker always wins when bit 18 set.
// - Client burst length at 23:20, high-priority client mask at 31:24.
// - With bit 16 set, invalidation and regular requests alternate in runs set by 7:0 and 15:8.
// - Bit 16 stalls regular requests so invalidation runs make progress.
module iommu_l2_cache_control #(
	parameter logic        DEV_PARITY_PRESENT = 1'b1,
	parameter logic [7:0]  DEV_WAY_COUNT      = 8'h04,
	parameter logic [3:0]  DEV_SIZE_EXPONENT  = 4'h6,
	parameter logic        INT_PARITY_PRESENT = 1'b1,
	parameter logic [7:0]  INT_WAY_COUNT      = 8'h04,
	parameter logic [3:0]  INT_SIZE_EXPONENT  = 4'h6
) (
	input  wire logic                          clk,
	input  wire logic                          reset,
	input  wire logic [7:0]                    reg_addr,
	input  wire logic [31:0]                   reg_wdata,
	input  wire logic                          reg_wr,
	input  wire logic                          reg_rd,
	output logic [31:0]                        reg_rdata,
	input  wire logic [7:0]                    client_req,
	output logic [7:0]                         client_grant,
	input  wire logic                          inval_req,
	output logic                               inval_grant,
	input  wire logic [15:0]                   req_id,
	output logic [15:0]                        dev_cache_index,
	input  wire logic                          hit_marked_invalid,
	output logic                               refetch,
	input  wire logic                          walker_credit_take,
	input  wire logic                          walker_credit_back,
	output logic                               walker_credit_ok,
	input  wire logic                          combiner_credit_take,
	input  wire logic                          combiner_credit_back,
	output logic                               combiner_credit_ok,
	input  wire logic                          cache_rsp_valid,
	input  wire logic                          walker_rsp_valid,
	output logic                               cache_rsp_take,
	output logic                               walker_rsp_take,
	output l2_cache_ctl_pkg::cache_cfg_t       dev_cfg,
	output l2_cache_ctl_pkg::cache_cfg_t       int_cfg,
	output l2_cache_ctl_pkg::l1_policy_t       l1_policy,
	output logic [15:0]                        dev_cache_way_off,
	output logic                               dev_cache_off
);
	import l2_cache_ctl_pkg::*;
	typedef enum logic {PH_REGULAR, PH_FLUSH} seq_phase_t;
	logic [7:0]  index_ff, nxt_index;
	logic [31:0] fix_a_ff, nxt_fix_a, fix_b_ff, nxt_fix_b;
	logic [31:0] core_ff, nxt_core, burst_ff, nxt_burst;
	logic [31:0] dctl_ff, nxt_dctl, hash_ff, nxt_hash, ways_ff, nxt_ways, ictl_ff, nxt_ictl;
	logic        dflush_ff, nxt_dflush, iflush_ff, nxt_iflush;
	logic [31:0] rdata_ff, nxt_rdata;
	logic        data_wr;
	logic [31:0] state_word;

	// Writes to the data port land in whichever register the index selects, except the read-only state word.
	assign data_wr = reg_wr && (reg_addr == PORT_DATA);
	// Register file next values; flush bits are pulses and never stored.
	always_comb begin
		nxt_index  = index_ff;
		nxt_fix_a  = fix_a_ff;
		nxt_fix_b  = fix_b_ff;
		nxt_core   = core_ff;
		nxt_burst  = burst_ff;
		nxt_dctl   = dctl_ff;
		nxt_hash   = hash_ff;
		nxt_ways   = ways_ff;
		nxt_ictl   = ictl_ff;
		nxt_dflush = 1'b0;
		nxt_iflush = 1'b0;
		if (reg_wr && reg_addr == PORT_INDEX) begin
			nxt_index = reg_wdata[7:0];
		end else if (data_wr) begin
			if (index_ff == OFS_FIX_A) begin
				nxt_fix_a = reg_wdata;
			end else if (index_ff == OFS_FIX_B) begin
				nxt_fix_b = reg_wdata;
			end else if (index_ff == OFS_CORE) begin
				nxt_core = reg_wdata & WMASK_CORE;
			end else if (index_ff == OFS_BURST) begin
				nxt_burst = reg_wdata & WMASK_BURST;
			end else if (index_ff == OFS_DEV_CTL) begin
				nxt_dctl   = reg_wdata & WMASK_CACHE_CTL;
				nxt_dflush = reg_wdata[CC_FLUSH];
			end else if (index_ff == OFS_DEV_HASH) begin
				nxt_hash = reg_wdata & WMASK_HASH;
			end else if (index_ff == OFS_DEV_WAYS) begin
				nxt_ways = reg_wdata;
			end else if (index_ff == OFS_INT_CTL) begin
				nxt_ictl   = reg_wdata & WMASK_CACHE_CTL;
				nxt_iflush = reg_wdata[CC_FLUSH];
			end
		end
	end

	// Read data: the index port reads back, the data port shows the selected register.
	always_comb begin
		nxt_rdata = RST_ZERO;
		if (reg_rd && reg_addr == PORT_INDEX) begin
			nxt_rdata = {24'h00_0000, index_ff};
		end else if (reg_rd && reg_addr == PORT_DATA) begin
			if (index_ff == OFS_FIX_A) begin
				nxt_rdata = fix_a_ff;
			end else if (index_ff == OFS_FIX_B) begin
				nxt_rdata = fix_b_ff;
			end else if (index_ff == OFS_STATE) begin
				nxt_rdata = state_word;
			end else if (index_ff == OFS_CORE) begin
				nxt_rdata = core_ff;
			end else if (index_ff == OFS_BURST) begin
				nxt_rdata = burst_ff;
			end else if (index_ff == OFS_DEV_CTL) begin
				nxt_rdata = {DEV_SIZE_EXPONENT, 4'h0, DEV_WAY_COUNT, DEV_PARITY_PRESENT,
					dctl_ff[14:0]};
			end else if (index_ff == OFS_DEV_HASH) begin
				nxt_rdata = hash_ff;
			end else if (index_ff == OFS_DEV_WAYS) begin
				nxt_rdata = ways_ff;
			end else if (index_ff == OFS_INT_CTL) begin
				nxt_rdata = {INT_SIZE_EXPONENT, 4'h0, INT_WAY_COUNT, INT_PARITY_PRESENT,
					ictl_ff[14:0]};
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			index_ff  <= 8'h00;
			fix_a_ff  <= RST_ZERO;
			fix_b_ff  <= RST_ZERO;
			core_ff   <= RST_CORE;
			burst_ff  <= RST_BURST;
			dctl_ff   <= RST_CACHE_CTL;
			hash_ff   <= RST_HASH;
			ways_ff   <= RST_ZERO;
			ictl_ff   <= RST_CACHE_CTL;
			dflush_ff <= 1'b0;
			iflush_ff <= 1'b0;
			rdata_ff  <= RST_ZERO;
		end else begin
			index_ff  <= nxt_index;
			fix_a_ff  <= nxt_fix_a;
			fix_b_ff  <= nxt_fix_b;
			core_ff   <= nxt_core;
			burst_ff  <= nxt_burst;
			dctl_ff   <= nxt_dctl;
			hash_ff   <= nxt_hash;
			ways_ff   <= nxt_ways;
			ictl_ff   <= nxt_ictl;
			dflush_ff <= nxt_dflush;
			iflush_ff <= nxt_iflush;
			rdata_ff  <= nxt_rdata;
		end
	end

	assign reg_rdata = rdata_ff;
	// Cache settings straight from the stored control words and the registered flush pulses.
	assign dev_cfg = '{inval_method: inval_method_t'(dctl_ff[CC_METHOD_LO +: 2]),
		flush_all: dflush_ff, skip: dctl_ff[CC_SKIP],
		replace_method: dctl_ff[CC_REPL_LO +: 2], replace_update_owner: dctl_ff[CC_OWNER],
		parity_on: dctl_ff[CC_PARITY]};
	assign int_cfg = '{inval_method: inval_method_t'(ictl_ff[CC_METHOD_LO +: 2]),
		flush_all: iflush_ff, skip: ictl_ff[CC_SKIP],
		replace_method: ictl_ff[CC_REPL_LO +: 2], replace_update_owner: ictl_ff[CC_OWNER],
		parity_on: ictl_ff[CC_PARITY]};
	assign l1_policy = '{xlate_req_page_lookup: core_ff[CO_PAGE_LOOKUP],
		first_level_keep_invalid_entries: core_ff[CO_KEEP_INVAL],
		first_level_keep_xlate_replies: core_ff[CO_KEEP_XLATE],
		untranslated_excl_return_page_entry: core_ff[CO_UNTR_EXCL],
		xlate_excl_return_page_entry: core_ff[CO_XL_EXCL]};

	// A way count of zero never turns the cache off; over sixteen, all sixteen mask bits must be set to turn it off.
	logic [15:0] all_ways_mask;
	assign all_ways_mask     = (DEV_WAY_COUNT == 8'h00 || DEV_WAY_COUNT > 8'h10) ? 16'hffff
		: 16'((17'h1_0000 >> (8'h10 - DEV_WAY_COUNT)) - 17'h1);
	assign dev_cache_way_off = ways_ff[15:0];
	assign dev_cache_off     = DEV_WAY_COUNT != 8'h00 &&
		((ways_ff[15:0] & all_ways_mask) == all_ways_mask);

	// Index hash; with an oversized sum of counts the bus bits shifted above bit 15 are dropped.
	logic [15:0] dev_index_ff, nxt_dev_index;
	logic        refetch_ff, nxt_refetch;
	always_comb begin
		logic [3:0]  fcnt, dcnt, bcnt;
		logic [15:0] fpart, dpart, bpart;
		fcnt  = {2'h0, hash_ff[HA_FUNC_LO +: 2]};
		dcnt  = {1'b0, hash_ff[HA_DEV_LO +: 3]};
		bcnt  = hash_ff[HA_BUS_LO +: 4];
		fpart = {13'h0000, req_id[2:0]} & ((16'h0001 << fcnt) - 16'h0001);
		dpart = {11'h000, req_id[7:3]} & ((16'h0001 << dcnt) - 16'h0001);
		bpart = {8'h00, req_id[15:8]} & ((16'h0001 << bcnt) - 16'h0001);
		nxt_dev_index = fpart | (dpart << fcnt) | (bpart << (fcnt + dcnt));
		nxt_refetch   = hit_marked_invalid && !core_ff[CO_NO_REFETCH];
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			dev_index_ff <= 16'h0000;
			refetch_ff   <= 1'b0;
		end else begin
			dev_index_ff <= nxt_dev_index;
			refetch_ff   <= nxt_refetch;
		end
	end

	assign dev_cache_index = dev_index_ff;
	assign refetch         = refetch_ff;
	// Credit counters reload whenever their field differs from last cycle's copy.
	logic [5:0] wcred_ff, nxt_wcred, ccred_ff, nxt_ccred, wshadow_ff, cshadow_ff;
	always_comb begin
		nxt_wcred = wcred_ff + 6'(walker_credit_back) - 6'(walker_credit_take && wcred_ff != 6'h00);
		nxt_ccred = ccred_ff + 6'(combiner_credit_back)
			- 6'(combiner_credit_take && ccred_ff != 6'h00);
		if (core_ff[CO_WCRED_LO +: 6] != wshadow_ff) begin
			nxt_wcred = core_ff[CO_WCRED_LO +: 6];
		end
		if (core_ff[CO_CCRED_LO +: 6] != cshadow_ff) begin
			nxt_ccred = core_ff[CO_CCRED_LO +: 6];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wcred_ff   <= RST_CREDIT;
			ccred_ff   <= RST_CREDIT;
			wshadow_ff <= RST_CREDIT;
			cshadow_ff <= RST_CREDIT;
		end else begin
			wcred_ff   <= nxt_wcred;
			ccred_ff   <= nxt_ccred;
			wshadow_ff <= core_ff[CO_WCRED_LO +: 6];
			cshadow_ff <= core_ff[CO_CCRED_LO +: 6];
		end
	end

	assign walker_credit_ok   = wcred_ff != 6'h00;
	assign combiner_credit_ok = ccred_ff != 6'h00;
	// Fault combiner: on a contested cycle the source not granted most recently goes first, unless the walker-wins bit is set.
	logic last_walker_ff, nxt_last_walker;
	always_comb begin
		walker_rsp_take = walker_rsp_valid && (!cache_rsp_valid || core_ff[CO_WALKER_WINS]
			|| !last_walker_ff);
		cache_rsp_take  = cache_rsp_valid && !walker_rsp_take;
		nxt_last_walker = last_walker_ff;
		if (walker_rsp_take || cache_rsp_take) begin
			nxt_last_walker = walker_rsp_take;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			last_walker_ff <= 1'b0;
		end else begin
			last_walker_ff <= nxt_last_walker;
		end
	end

	// Client arbiter with burst runs, interleaved with sequential invalidation runs.
	seq_phase_t phase_ff, nxt_phase;
	logic [2:0] owner_ff, nxt_owner;
	logic [3:0] burst_cnt_ff, nxt_burst_cnt;
	logic [7:0] run_cnt_ff, nxt_run_cnt;
	logic       regular_ok;
	always_comb begin
		logic [3:0] blen;
		logic [7:0] flen, rlen, hp, pool;
		logic [2:0] cand;
		logic       found;
		blen = (core_ff[CO_BURST_LO +: 4] == 4'h0) ? 4'h1 : core_ff[CO_BURST_LO +: 4];
		flen = (burst_ff[BU_FLUSH_LO +: 8] == 8'h00) ? 8'h01 : burst_ff[BU_FLUSH_LO +: 8];
		rlen = (burst_ff[BU_REG_LO +: 8] == 8'h00) ? 8'h01 : burst_ff[BU_REG_LO +: 8];
		hp   = client_req & core_ff[CO_PRIO_LO +: 8];
		pool = (hp != 8'h00) ? hp : client_req;
		nxt_phase     = phase_ff;
		nxt_run_cnt   = run_cnt_ff;
		nxt_owner     = owner_ff;
		nxt_burst_cnt = burst_cnt_ff;
		client_grant  = 8'h00;
		inval_grant   = 1'b0;
		found         = 1'b0;
		cand          = owner_ff;
		// Without stalling, invalidation only gets the caches when no client asks.
		if (burst_ff[BU_STALL]) begin
			regular_ok  = !(inval_req && (phase_ff == PH_FLUSH || client_req == 8'h00));
			inval_grant = inval_req && !regular_ok;
		end else begin
			regular_ok  = 1'b1;
			inval_grant = inval_req && client_req == 8'h00;
		end
		if (regular_ok) begin
			if (client_req[owner_ff] && burst_cnt_ff + 4'h1 < blen
				&& (hp == 8'h00 || hp[owner_ff])) begin
				found = 1'b1;
			end else begin
				for (int i = 1; i <= 8; i++) begin
					if (!found && pool[3'(owner_ff + 3'(i))]) begin
						found = 1'b1;
						cand  = 3'(owner_ff + 3'(i));
					end
				end
			end
		end
		if (found) begin
			client_grant[cand] = 1'b1;
			nxt_burst_cnt      = (cand == owner_ff) ? burst_cnt_ff + 4'h1 : 4'h0;
			nxt_owner          = cand;
		end
		// Phase bookkeeping counts grants inside each run.
		case (phase_ff)
			PH_FLUSH: begin
				if (!inval_req) begin
					nxt_phase   = PH_REGULAR;
					nxt_run_cnt = 8'h00;
				end else if (inval_grant && run_cnt_ff + 8'h01 >= flen && client_req != 8'h00) begin
					nxt_phase   = PH_REGULAR;
					nxt_run_cnt = 8'h00;
				end else if (inval_grant) begin
					nxt_run_cnt = run_cnt_ff + 8'h01;
				end
			end
			default: begin
				if (burst_ff[BU_STALL] && inval_req
					&& (client_req == 8'h00 || (found && run_cnt_ff + 8'h01 >= rlen))) begin
					nxt_phase   = PH_FLUSH;
					nxt_run_cnt = (client_req == 8'h00) ? 8'h01 : 8'h00;
				end else if (found) begin
					nxt_run_cnt = (run_cnt_ff == 8'hff) ? run_cnt_ff : run_cnt_ff + 8'h01;
				end
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			phase_ff     <= PH_REGULAR;
			owner_ff     <= 3'h7;
			burst_cnt_ff <= 4'h0;
			run_cnt_ff   <= 8'h00;
		end else begin
			phase_ff     <= nxt_phase;
			owner_ff     <= nxt_owner;
			burst_cnt_ff <= nxt_burst_cnt;
			run_cnt_ff   <= nxt_run_cnt;
		end
	end

	assign state_word = {8'h00, run_cnt_ff, 3'h0, phase_ff == PH_FLUSH, burst_cnt_ff,
		1'b0, owner_ff, wcred_ff[3:0]};
	AST_FLUSH_PULSE: assert property (@(posedge clk) disable iff (reset)
		data_wr && index_ff == OFS_DEV_CTL && reg_wdata[CC_FLUSH] |=> dev_cfg.flush_all ##1
		(!dev_cfg.flush_all || $past(data_wr && index_ff == OFS_DEV_CTL && reg_wdata[CC_FLUSH])))
		else $error("device cache flush pulse wrong");
	AST_SKIP_FOLLOWS: assert property (@(posedge clk) disable iff (reset)
		data_wr && index_ff == OFS_INT_CTL |=> int_cfg.skip == $past(reg_wdata[CC_SKIP]))
		else $error("interrupt cache skip not taken from write");
	AST_REFETCH: assert property (@(posedge clk) disable iff (reset)
		hit_marked_invalid && !core_ff[CO_NO_REFETCH] |=> refetch)
		else $error("invalid hit did not refetch");
	AST_WALKER_WINS: assert property (@(posedge clk) disable iff (reset)
		core_ff[CO_WALKER_WINS] && walker_rsp_valid |-> walker_rsp_take && !cache_rsp_take)
		else $error("walker lost with fixed priority");
	AST_ROUND_ROBIN: assert property (@(posedge clk) disable iff (reset)
		!core_ff[CO_WALKER_WINS] && walker_rsp_take && cache_rsp_valid ##1
		!core_ff[CO_WALKER_WINS] && walker_rsp_valid && cache_rsp_valid |-> cache_rsp_take)
		else $error("round robin did not alternate");
	AST_CREDIT_RELOAD: assert property (@(posedge clk) disable iff (reset)
		data_wr && index_ff == OFS_CORE && reg_wdata[CO_WCRED_LO +: 6] != core_ff[CO_WCRED_LO +: 6]
		|-> ##2 wcred_ff == $past(reg_wdata[CO_WCRED_LO +: 6], 2))
		else $error("walker credits not reloaded");
	AST_STALL_REGULAR: assert property (@(posedge clk) disable iff (reset)
		burst_ff[BU_STALL] && phase_ff == PH_FLUSH && inval_req |-> client_grant == 8'h00 && inval_grant)
		else $error("regular request passed during invalidation run");
	AST_ONE_GRANT: assert property (@(posedge clk) disable iff (reset)
		$onehot0(client_grant) && (client_grant == 8'h00 || (client_grant & client_req) != 8'h00)
		&& !(inval_grant && client_grant != 8'h00))
		else $error("client grant malformed");
	AST_READ_ONLY: assert property (@(posedge clk) disable iff (reset)
		reg_rd && reg_addr == PORT_DATA && index_ff == OFS_DEV_CTL
		|=> reg_rdata[23:16] == DEV_WAY_COUNT && reg_rdata[31:28] == DEV_SIZE_EXPONENT)
		else $error("device cache size fields wrong");

endmodule : iommu_l2_cache_control

// >>> inc/l2_cache_ctl_pkg.sv
package l2_cache_ctl_pkg;

	// Port-facing addresses of the indirect window (byte addresses).
	localparam logic [7:0] PORT_INDEX = 8'h00;
	localparam logic [7:0] PORT_DATA  = 8'h04;

	// Register offsets inside the indirect space.
	localparam logic [7:0] OFS_FIX_A      = 8'h06;
	localparam logic [7:0] OFS_FIX_B      = 8'h07;
	localparam logic [7:0] OFS_STATE      = 8'h08;
	localparam logic [7:0] OFS_CORE       = 8'h0c;
	localparam logic [7:0] OFS_BURST      = 8'h0d;
	localparam logic [7:0] OFS_DEV_CTL    = 8'h10;
	localparam logic [7:0] OFS_DEV_HASH   = 8'h11;
	localparam logic [7:0] OFS_DEV_WAYS   = 8'h12;
	localparam logic [7:0] OFS_INT_CTL    = 8'h14;

	// Values after reset.
	localparam logic [31:0] RST_ZERO      = 32'h0000_0000;
	localparam logic [31:0] RST_CORE      = 32'h0010_4040;
	localparam logic [31:0] RST_BURST     = 32'h0001_0808;
	localparam logic [31:0] RST_CACHE_CTL = 32'h0000_0001;
	localparam logic [31:0] RST_HASH      = 32'h0000_0062;
	localparam logic [5:0]  RST_CREDIT    = 6'h04;

	// Writable bits of each register.
	localparam logic [31:0] WMASK_CORE      = 32'hfff7_ffff;
	localparam logic [31:0] WMASK_BURST     = 32'hff01_ffff;
	localparam logic [31:0] WMASK_CACHE_CTL = 32'h0000_231b;
	localparam logic [31:0] WMASK_HASH      = 32'h0000_01ff;

	// Field positions shared by both cache control registers.
	localparam int CC_REPL_LO   = 0;
	localparam int CC_OWNER     = 3;
	localparam int CC_PARITY    = 4;
	localparam int CC_METHOD_LO = 8;
	localparam int CC_FLUSH     = 10;
	localparam int CC_SKIP      = 13;
	localparam int CC_PRESENT   = 15;
	localparam int CC_WAYS_LO   = 16;
	localparam int CC_SIZE_LO   = 28;

	// Field positions of the core control register.
	localparam int CO_PAGE_LOOKUP = 0;
	localparam int CO_KEEP_INVAL  = 1;
	localparam int CO_KEEP_XLATE  = 2;
	localparam int CO_NO_REFETCH  = 3;
	localparam int CO_WCRED_LO    = 4;
	localparam int CO_UNTR_EXCL   = 10;
	localparam int CO_XL_EXCL     = 11;
	localparam int CO_CCRED_LO    = 12;
	localparam int CO_WALKER_WINS = 18;
	localparam int CO_BURST_LO    = 20;
	localparam int CO_PRIO_LO     = 24;

	// Field positions of the invalidation burst register and the hash register.
	localparam int BU_FLUSH_LO = 0;
	localparam int BU_REG_LO   = 8;
	localparam int BU_STALL    = 16;
	localparam int HA_FUNC_LO  = 0;
	localparam int HA_DEV_LO   = 2;
	localparam int HA_BUS_LO   = 5;

	// Invalidation methods.
	typedef enum logic [1:0] {
		INV_WHOLE        = 2'h0,
		INV_FAST         = 2'h1,
		INV_SEQ_PRECISE  = 2'h2,
		INV_SEQ_PARTIAL  = 2'h3
	} inval_method_t;

	// Per-cache settings handed to the cache datapath.
	typedef struct packed {
		inval_method_t inval_method;
		logic          flush_all;
		logic          skip;
		logic [1:0]    replace_method;
		logic          replace_update_owner;
		logic          parity_on;
	} cache_cfg_t;

	// Policy bits handed to the first level and the lookup path.
	typedef struct packed {
		logic xlate_req_page_lookup;
		logic first_level_keep_invalid_entries;
		logic first_level_keep_xlate_replies;
		logic untranslated_excl_return_page_entry;
		logic xlate_excl_return_page_entry;
	} l1_policy_t;

endpackage : l2_cache_ctl_pkg

// >>> verif/l2_far_side.sv
// Table walker and fault combiner side: each response is offered until taken.
module l2_far_side (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic [1:0] arm,
	input  wire logic       cache_rsp_take,
	input  wire logic       walker_rsp_take,
	output logic            cache_rsp_valid,
	output logic            walker_rsp_valid
);
	timeunit 1ns;
	timeprecision 1ps;
	// A real source never withdraws an offer, so valid drops only after a take.
	always_ff @(posedge clk) begin
		if (reset) begin
			cache_rsp_valid <= 1'b0;
			walker_rsp_valid <= 1'b0;
		end else begin
			cache_rsp_valid <= arm[0] | (cache_rsp_valid & ~cache_rsp_take);
			walker_rsp_valid <= arm[1] | (walker_rsp_valid & ~walker_rsp_take);
		end
	end
endmodule : l2_far_side

// >>> verif/iommu_l2_cache_control_test.sv
module iommu_l2_cache_control_test;
	timeunit 1ns;
	timeprecision 1ps;
	import l2_cache_ctl_pkg::*;
	logic clk, reset, reg_wr, reg_rd, inval_req, hit_marked_invalid;
	logic wc_take, wc_back, cc_take, cc_back, c_ok, w_ok, c_valid, w_valid, c_take, w_take;
	logic inval_grant, refetch, dev_cache_off;
	logic [1:0] arm;
	logic [7:0] reg_addr, client_req, client_grant;
	logic [15:0] req_id, dev_cache_index, dev_cache_way_off;
	logic [31:0] reg_wdata, reg_rdata;
	cache_cfg_t dev_cfg, int_cfg;
	l1_policy_t l1_policy;
	int n_errors = 0;
	int total_checks = 0;
	typedef struct {logic [7:0] ofs; logic [31:0] rst, wd, exp;} row_t;
	// Reset value, written value and read-back value of six registers and one unused offset.
	row_t rows[7] = '{
		'{8'h06, 32'h0, 32'hffffffff, 32'hffffffff},
		'{8'h0c, 32'h00104040, 32'hfff44c4f, 32'hfff44c4f},
		'{8'h0d, 32'h00010808, 32'hffffffff, 32'hff01ffff},
		'{8'h10, 32'h60048001, 32'hffffffff, 32'h6004a31b},
		'{8'h11, 32'h00000062, 32'hffffffff, 32'h000001ff},
		'{8'h14, 32'h60048001, 32'hffffffff, 32'h6004a31b},
		'{8'h05, 32'h0, 32'hffffffff, 32'h0}};

	iommu_l2_cache_control u_iommu_l2_cache_control (.clk(clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .client_req(client_req), .client_grant(client_grant),
		.inval_req(inval_req), .inval_grant(inval_grant), .req_id(req_id),
		.dev_cache_index(dev_cache_index), .hit_marked_invalid(hit_marked_invalid),
		.refetch(refetch), .walker_credit_take(wc_take), .walker_credit_back(wc_back),
		.walker_credit_ok(w_ok), .combiner_credit_take(cc_take),
		.combiner_credit_back(cc_back), .combiner_credit_ok(c_ok),
		.cache_rsp_valid(c_valid), .walker_rsp_valid(w_valid), .cache_rsp_take(c_take),
		.walker_rsp_take(w_take), .dev_cfg(dev_cfg), .int_cfg(int_cfg),
		.l1_policy(l1_policy), .dev_cache_way_off(dev_cache_way_off),
		.dev_cache_off(dev_cache_off));
	l2_far_side u_l2_far_side (.clk(clk), .reset(reset), .arm(arm), .cache_rsp_take(c_take),
		.walker_rsp_take(w_take), .cache_rsp_valid(c_valid), .walker_rsp_valid(w_valid));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One write strobe cycle; the strobe is dropped at the following edge.
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task wr_reg(input logic [7:0] ofs, input logic [31:0] d);
		wr(PORT_INDEX, {24'h0, ofs});
		wr(PORT_DATA, d);
		@(negedge clk);
	endtask : wr_reg

	// Read data stand only in the cycle after the strobe.
	task rd_chk(input logic [7:0] ofs, input logic [31:0] exp);
		wr(PORT_INDEX, {24'h0, ofs});
		reg_addr <= PORT_DATA;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata, exp);
	endtask : rd_chk

	task do_reset;
		@(posedge clk);
		reset <= 1'b1;
		repeat (5) @(posedge clk);
		reset <= 1'b0;
	endtask : do_reset

	task results;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : results

	// Watchdog far beyond the 147 cycles the sequence needs.
	initial begin
		#200us;
		n_errors++;
		results();
	end

	initial begin
		{reset, reg_wr, reg_rd, inval_req, hit_marked_invalid} = 5'h10;
		{wc_take, wc_back, cc_take, cc_back, arm} = 6'h0;
		{reg_addr, client_req, req_id, reg_wdata} = 64'h0;
		do_reset();
		foreach (rows[i]) begin
			rd_chk(rows[i].ofs, rows[i].rst);
			wr_reg(rows[i].ofs, rows[i].wd);
			rd_chk(rows[i].ofs, rows[i].exp);
		end
		chk(l1_policy, 32'h1f);
		chk({dev_cfg.skip, int_cfg.skip}, 32'h3);
		chk({dev_cfg, int_cfg}, 32'hdfdf);
		do_reset();
		client_req <= 8'h03;
		arm <= 2'h3;
		@(negedge clk);
		chk(client_grant, 32'h01);
		@(negedge clk);
		chk(client_grant, 32'h02);
		chk({w_take, c_take}, 32'h2);
		@(posedge clk);
		{client_req, arm} <= 10'h0;
		inval_req <= 1'b1;
		hit_marked_invalid <= 1'b1;
		req_id <= 16'hab05;
		@(negedge clk);
		chk(inval_grant, 32'h1);
		chk(c_take, 32'h1);
		@(posedge clk);
		inval_req <= 1'b0;
		hit_marked_invalid <= 1'b0;
		wc_take <= 1'b1;
		@(negedge clk);
		chk(refetch, 32'h1);
		repeat (4) @(posedge clk);
		wc_take <= 1'b0;
		@(negedge clk);
		chk(w_ok, 32'h0);
		chk(c_ok, 32'h1);
		chk(dev_cache_index, 32'h0d);
		// Credit field moves while every walker credit is still taken, so the counter reloads.
		wr_reg(OFS_CORE, 32'h00004018);
		@(posedge clk);
		hit_marked_invalid <= 1'b1;
		repeat (2) @(negedge clk);
		chk(refetch, 32'h0);
		chk(w_ok, 32'h1);
		// Fixed priority must beat the turn the cache has just earned.
		wr_reg(OFS_CORE, 32'h00044018);
		@(posedge clk);
		hit_marked_invalid <= 1'b0;
		arm <= 2'h3;
		repeat (2) @(posedge clk);
		arm <= 2'h0;
		@(negedge clk);
		chk({w_take, c_take}, 32'h2);
		for (int m = 0; m < 4; m++) begin
			wr_reg(OFS_DEV_CTL, 32'(m) << 8);
			wr_reg(OFS_INT_CTL, 32'(3 - m) << 8);
			chk({dev_cfg.inval_method, int_cfg.inval_method}, 32'(m * 4 + 3 - m));
		end
		wr(PORT_INDEX, {24'h0, OFS_DEV_CTL});
		wr(PORT_DATA, 32'h400);
		@(negedge clk);
		chk(dev_cfg.flush_all, 32'h1);
		@(negedge clk);
		chk(dev_cfg.flush_all, 32'h0);
		wr_reg(OFS_DEV_WAYS, 32'h7);
		chk({dev_cache_way_off, 15'h0, dev_cache_off}, 32'h00070000);
		wr_reg(OFS_DEV_WAYS, 32'hf);
		chk(dev_cache_off, 32'h1);
		results();
	end
endmodule : iommu_l2_cache_control_test
